//--- src/gp_timer_up_counting.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
// Behaviour
// RL1: four event sources, overflow, underflow, compare, period, each with own flag
// RL2: compare flag set two clocks after match when compare is enabled
// RL3: overflow means counter reaches all-ones; underflow means counter reaches zero
// RL4: period event on counter equal period; flags set two clocks later
// RL5: mode field selects one of six counting modes; the three up/down modes are not built and hold like stop
// RL6: enable clear stops counting and resets prescaler; set starts counting
// RL7: stop/hold keeps counter, compare output and prescale counter unchanged
// RL8: single-up counts to period, next tick returns zero, clears enable
// RL9: selected period or underflow event pulses ADC start as flag sets
// RL10: flag requests interrupt only if unmasked and no higher unmasked pending
// RL11: single-up period from zero lasts period plus one scaled clocks
// RL12: counter above period counts to all-ones, wraps, continues from zero
// RL13: single-up starting at period: period flag, zero, underflow flag, done
// RL14: software must rewrite enable to start another single-up run
// RL15: up modes report direction one and ignore direction pin
// RL16: counting begins immediately after enable is set
// RL17: continuous-up returns to zero after period match, losing no tick
// RL18: continuous-up periods last period plus one scaled clocks
// RL19: continuous-up starting at period: period flag, zero, underflow, continue
// RL20: count source selectable between CPU clock and external timer clock
// RL21: counter between zero and period counts up to period, then finishes
// RL22: flag timing identical in every counting mode
// RL23: working period loads from shadow only while counter is zero
// RL24: after single-up ends, counter holds zero with no further flags
module gp_timer_up_counting
    import gp_timer_pkg::*;
#(
    parameter int PRESC_LOG2 = PRESC_MAX_LOG2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port: one access per strobe, never stalls
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // timer pins, both taken on clk_i
    input  wire logic        ext_clk_i,
    input  wire logic        count_direction_pin_i,
    // event and status outputs
    output logic             adc_start_o,
    output logic             irq_o,
    output logic      [1:0]  irq_src_o,
    output logic      [3:0]  event_flags_o,
    output logic      [15:0] counter_o
);

    // the prescale field is three bits, so the counter must reach 2^7 - 1;
    // a narrower one would wrap early and shorten the scaled ticks of the largest prescale settings
    if (PRESC_LOG2 != PRESC_MAX_LOG2) begin : g_bad_presc
        $error("prescale counter width must match the 3-bit prescale field");
    end

    // whole state in one record: one next-state and one register process
    typedef struct packed {
        logic [15:0]           ctrl;
        logic [1:0]            adc_sel;
        logic [15:0]           cnt;
        logic [15:0]           cmp;
        logic [15:0]           per_sh;
        logic [15:0]           per;
        logic [EVT_COUNT-1:0]  flags;
        logic [EVT_COUNT-1:0]  mask;
        logic [PRESC_LOG2-1:0] pscnt;
        logic                  ext_q;
        logic                  fresh;
        logic                  adc;
        logic [15:0]           rdata;
    } timer_s;

    timer_s q_r;
    timer_s q_nxt;

    // decoded control fields
    logic                  enabled;
    logic [2:0]            mode;
    logic [2:0]            presc;
    logic [1:0]            clksel;
    logic                  up_mode;

    // count source and events
    logic                  src_tick;
    logic [PRESC_LOG2-1:0] presc_lim;
    logic                  scaled_tick;
    logic [EVT_COUNT-1:0]  evt_now;
    logic [EVT_COUNT-1:0]  evt_late;
    logic [EVT_COUNT-1:0]  pending;

    // status and interrupt selection
    logic                  dir_bit;
    logic [1:0]            top_src;
    logic                  top_any;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    // fields come straight from the stored control word
    assign enabled = q_r.ctrl[TIMER_ENABLE_BIT];
    assign mode    = q_r.ctrl[CTRL_MODE_LSB +: 3];                    // [RL5]
    assign presc   = q_r.ctrl[CTRL_PRESC_LSB +: 3];
    assign clksel  = q_r.ctrl[CTRL_CLKSEL_LSB +: 2];
    assign up_mode = (mode == MODE_SINGLE_UP) || (mode == MODE_CONT_UP);

    // up/down modes are not built here: the direction bit follows the pin in the
    // directional mode only, so software still sees a sensible indication
    assign dir_bit = up_mode ? 1'b1 :                                 // [RL15]
                     ((mode == MODE_DIR_UPDOWN) ? count_direction_pin_i : 1'b1);

    // ------------------------------------------------------------
    // count source and prescaler
    // ------------------------------------------------------------
    // external clock must be at most a quarter of the CPU clock so each
    // high and low phase is seen; a rising edge counts once
    assign src_tick = (clksel == CLKSEL_EXTERNAL) ? (ext_clk_i & ~q_r.ext_q)   // [RL20]
                                                  : 1'b1;
    // divide by 2^n: the count runs 0 .. 2^n - 1 between scaled ticks
    assign presc_lim = PRESC_LOG2'((8'h01 << presc) - 8'h01);
    assign scaled_tick = enabled && up_mode && src_tick && (q_r.pscnt == presc_lim);

    // ------------------------------------------------------------
    // event detection on a freshly reached counter value
    // ------------------------------------------------------------
    // fresh marks the first cycle of a new counter value or of a start, so a
    // value held for many cycles raises its event only once;
    // limitation: a value loaded by software raises no event
    always_comb begin
        evt_now = '0;
        if (q_r.fresh) begin
            evt_now[EVT_PERIOD]    = (q_r.cnt == q_r.per);             // [RL4]
            evt_now[EVT_COMPARE]   = (q_r.cnt == q_r.cmp) &&
                                     q_r.ctrl[CTRL_CMP_EN_BIT];        // [RL2]
            evt_now[EVT_UNDERFLOW] = (q_r.cnt == COUNT_ZERO);          // [RL3]
            evt_now[EVT_OVERFLOW]  = (q_r.cnt == COUNT_ALL_ONES);      // [RL3]
        end
    end

    // one stage here plus the flag register gives the two-clock latency,
    // the same path for every mode; flags and adc start move together
    event_delay #(
        .WIDTH  (EVT_COUNT),
        .STAGES (EVT_PIPE_STAGES)
    ) u_event_delay (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .evt_i  (evt_now),
        .evt_o  (evt_late)
    );                                                                // [RL22]

    // ------------------------------------------------------------
    // interrupt request with fixed priority inside the group
    // ------------------------------------------------------------
    assign pending = q_r.flags & q_r.mask;

    // scan from low priority up, so the last hit is the highest

    always_comb begin
        top_src = 2'h0;
        top_any = 1'b0;
        for (int i = EVT_COUNT - 1; i >= 0; i--) begin
            if (pending[i]) begin
                top_src = 2'(i);                                      // [RL10]
                top_any = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        q_nxt       = q_r;
        q_nxt.ext_q = ext_clk_i;
        q_nxt.fresh = 1'b0;

        // counting
        // a disabled timer parks its prescaler so a restart gets a full tick;
        // up/down modes are not built and hold like stop
        if (!enabled) begin
            q_nxt.pscnt = '0;                                         // [RL6]
        end else if (mode == MODE_STOP_HOLD || !up_mode) begin
            q_nxt.pscnt = q_r.pscnt;                                  // [RL7]
        end else if (src_tick) begin
            if (scaled_tick) begin
                q_nxt.pscnt = '0;
            end else begin
                q_nxt.pscnt = q_r.pscnt + PRESC_LOG2'(1);
            end
        end

        // the period match is tested before the increment, so a counter
        // above the period runs on through all-ones and wraps first
        if (scaled_tick) begin
            q_nxt.fresh = 1'b1;
            if (q_r.cnt == q_r.per) begin
                q_nxt.cnt = COUNT_ZERO;                               // [RL8] [RL17] [RL13] [RL19]
                if (mode == MODE_SINGLE_UP) begin
                    q_nxt.ctrl[TIMER_ENABLE_BIT] = 1'b0;              // [RL8] [RL24] [RL14]
                end
            end else begin
                // plain increment also carries all-ones back to zero
                q_nxt.cnt = q_r.cnt + 16'h0001;                       // [RL12] [RL21] [RL11] [RL18]
            end
        end

        // working period follows the shadow while the counter sits at zero,
        // so a new period never cuts short the one in progress
        if (q_r.cnt == COUNT_ZERO) begin
            q_nxt.per = q_r.per_sh;                                   // [RL23]
        end

        // ADC start leaves in the cycle the flag becomes visible;
        // compare as a source shares the same timing
        q_nxt.adc = 1'b0;
        case (q_r.adc_sel)
            ADC_SEL_UNDERFLOW: q_nxt.adc = evt_late[EVT_UNDERFLOW];   // [RL9]
            ADC_SEL_PERIOD:    q_nxt.adc = evt_late[EVT_PERIOD];      // [RL9]
            ADC_SEL_COMPARE:   q_nxt.adc = evt_late[EVT_COMPARE];
            default:           q_nxt.adc = 1'b0;
        endcase

        // software writes win over what counting computed above
        if (wr_i) begin
            case (addr_i)
                TIMER_CONTROL_REG_IDX: begin
                    q_nxt.ctrl = wdata_i;
                    if (wdata_i[TIMER_ENABLE_BIT] && !enabled) begin
                        // start checks the present value at once
                        q_nxt.fresh = 1'b1;                           // [RL16] [RL13] [RL19]
                        q_nxt.pscnt = '0;
                    end
                end
                TIMER_GROUP_CONTROL_REG_IDX: begin
                    q_nxt.adc_sel = wdata_i[GRP_ADC_SEL_LSB +: 2];
                end
                COUNTER_REG_IDX: begin
                    // a loaded value is not checked for events
                    q_nxt.cnt   = wdata_i;
                    q_nxt.fresh = 1'b0;
                end
                COMPARE_REG_IDX: begin
                    q_nxt.cmp = wdata_i;
                end
                PERIOD_REG_IDX: begin
                    q_nxt.per_sh = wdata_i;                           // [RL23]
                end
                EVENT_MASK_REG_IDX: begin
                    q_nxt.mask = wdata_i[EVT_COUNT-1:0];
                end
                default: begin
                    q_nxt.mask = q_r.mask;
                end
            endcase
        end

        // flags: write one to clear, a same-cycle set wins;
        // the set comes last so no event is lost to a clear
        if (wr_i && addr_i == EVENT_FLAG_REG_IDX) begin
            q_nxt.flags = q_r.flags & ~wdata_i[EVT_COUNT-1:0];
        end
        q_nxt.flags = q_nxt.flags | evt_late;                         // [RL1] [RL2] [RL4]

        // read data stands only in the cycle after the strobe;
        // reads have no side effects
        q_nxt.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                TIMER_CONTROL_REG_IDX:       q_nxt.rdata = q_r.ctrl;
                TIMER_GROUP_CONTROL_REG_IDX: begin
                    q_nxt.rdata[GRP_ADC_SEL_LSB +: 2] = q_r.adc_sel;
                    q_nxt.rdata[GRP_DIR_BIT]          = dir_bit;      // [RL15]
                end
                COUNTER_REG_IDX:             q_nxt.rdata = q_r.cnt;
                COMPARE_REG_IDX:             q_nxt.rdata = q_r.cmp;
                PERIOD_REG_IDX:              q_nxt.rdata = q_r.per_sh;
                EVENT_FLAG_REG_IDX:          q_nxt.rdata[EVT_COUNT-1:0] = q_r.flags;
                EVENT_MASK_REG_IDX:          q_nxt.rdata[EVT_COUNT-1:0] = q_r.mask;
                PERIOD_ACTIVE_REG_IDX:       q_nxt.rdata = q_r.per;
                default:                     q_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset brings every field to its reset value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r.ctrl    <= CTRL_RESET;
            q_r.adc_sel <= ADC_SEL_RESET;
            q_r.cnt     <= COUNTER_RESET;
            q_r.cmp     <= COMPARE_RESET;
            q_r.per_sh  <= PERIOD_RESET;
            q_r.per     <= PERIOD_RESET;
            q_r.flags   <= FLAGS_RESET;
            q_r.mask    <= MASK_RESET;
            q_r.pscnt   <= '0;
            q_r.ext_q   <= 1'b0;
            q_r.fresh   <= 1'b0;
            q_r.adc     <= 1'b0;
            q_r.rdata   <= 16'h0000;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // irq is combinational from registered flags and mask
    assign rdata_o       = q_r.rdata;
    assign adc_start_o   = q_r.adc;
    assign irq_o         = top_any;                                   // [RL10]
    assign irq_src_o     = top_src;
    assign event_flags_o = q_r.flags;
    assign counter_o     = q_r.cnt;

endmodule // gp_timer_up_counting

//--- src/gp_timer_pkg.sv
package gp_timer_pkg;

    // ------------------------------------------------------------
    // register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] TIMER_CONTROL_REG_IDX       = 4'h0;
    localparam logic [3:0] TIMER_GROUP_CONTROL_REG_IDX = 4'h1;
    localparam logic [3:0] COUNTER_REG_IDX             = 4'h2;
    localparam logic [3:0] COMPARE_REG_IDX             = 4'h3;
    localparam logic [3:0] PERIOD_REG_IDX              = 4'h4;
    localparam logic [3:0] EVENT_FLAG_REG_IDX          = 4'h5;
    localparam logic [3:0] EVENT_MASK_REG_IDX          = 4'h6;
    localparam logic [3:0] PERIOD_ACTIVE_REG_IDX       = 4'h7;

    // ------------------------------------------------------------
    // timer_control_reg fields
    // ------------------------------------------------------------
    localparam int CTRL_CMP_EN_BIT  = 1;
    localparam int CTRL_CLKSEL_LSB  = 4;
    localparam int TIMER_ENABLE_BIT = 6;
    localparam int CTRL_PRESC_LSB   = 8;
    localparam int CTRL_MODE_LSB    = 11;

    localparam logic [1:0] CLKSEL_INTERNAL = 2'h0;
    localparam logic [1:0] CLKSEL_EXTERNAL = 2'h1;

    localparam logic [2:0] MODE_STOP_HOLD    = 3'h0;
    localparam logic [2:0] MODE_SINGLE_UP    = 3'h1;
    localparam logic [2:0] MODE_CONT_UP      = 3'h2;
    localparam logic [2:0] MODE_DIR_UPDOWN   = 3'h3;
    localparam logic [2:0] MODE_SINGLE_UPDN  = 3'h4;
    localparam logic [2:0] MODE_CONT_UPDN    = 3'h5;

    // ------------------------------------------------------------
    // timer_group_control_reg fields
    // ------------------------------------------------------------
    localparam int GRP_ADC_SEL_LSB = 7;
    localparam int GRP_DIR_BIT     = 13;

    localparam logic [1:0] ADC_SEL_NONE      = 2'h0;
    localparam logic [1:0] ADC_SEL_UNDERFLOW = 2'h1;
    localparam logic [1:0] ADC_SEL_PERIOD    = 2'h2;
    localparam logic [1:0] ADC_SEL_COMPARE   = 2'h3;

    // ------------------------------------------------------------
    // event flag positions, also the interrupt priority order
    // ------------------------------------------------------------
    localparam int EVT_PERIOD    = 0;
    localparam int EVT_COMPARE   = 1;
    localparam int EVT_UNDERFLOW = 2;
    localparam int EVT_OVERFLOW  = 3;
    localparam int EVT_COUNT     = 4;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [1:0]  ADC_SEL_RESET = 2'h0;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'h0000;
    localparam logic [3:0]  FLAGS_RESET   = 4'h0;
    localparam logic [3:0]  MASK_RESET    = 4'h0;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;

    localparam int CPU_CLK_MHZ     = 10;
    localparam int EVT_DELAY_CYC   = 2;
    localparam int EVT_PIPE_STAGES = EVT_DELAY_CYC - 1;
    localparam int PRESC_MAX_LOG2  = 7;

endpackage

//--- src/event_delay.sv
`timescale 1ns/1ns
module event_delay
    import gp_timer_pkg::*;
#(
    parameter int WIDTH  = 4,
    parameter int STAGES = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] evt_i,
    output logic      [WIDTH-1:0] evt_o
);

    if (STAGES < 1 || WIDTH < 1) begin : g_bad_size
        $error("event_delay needs at least one stage and one bit");
    end

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] pipe;
    } delay_s;

    delay_s q_r;
    delay_s q_nxt;

    // ------------------------------------------------------------
    // shift stages
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.pipe[0] = evt_i;
        for (int i = 1; i < STAGES; i++) begin
            q_nxt.pipe[i] = q_r.pipe[i-1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign evt_o = q_r.pipe[STAGES-1];

endmodule // event_delay

//--- verif/gp_timer_sva.sv
`timescale 1ns/1ns
module gp_timer_sva
    import gp_timer_pkg::*;
#(
    parameter int PRESC_LOG2 = PRESC_MAX_LOG2
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        ext_clk_i,
    input wire logic        count_direction_pin_i,
    input wire logic        adc_start_o,
    input wire logic        irq_o,
    input wire logic [1:0]  irq_src_o,
    input wire logic [3:0]  event_flags_o,
    input wire logic [15:0] counter_o
);
    // ------------------------------------------------------------
    // one clock domain, so clocking and disable are shared
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_uf_delay;
        $rose(event_flags_o[EVT_UNDERFLOW]) |-> $past(counter_o, 2) == COUNT_ZERO;
    endproperty
    a_uf_delay: assert property (p_uf_delay)
        else $error("underflow flag not two cycles after zero");

    property p_ovf_delay;
        $rose(event_flags_o[EVT_OVERFLOW]) |-> $past(counter_o, 2) == COUNT_ALL_ONES;
    endproperty
    a_ovf_delay: assert property (p_ovf_delay)
        else $error("overflow flag not two cycles after all ones");

    property p_irq_none;
        event_flags_o == 4'h0 |-> !irq_o && irq_src_o == 2'h0;
    endproperty
    a_irq_none: assert property (p_irq_none)
        else $error("interrupt without a flag");

    property p_irq_src;
        irq_o |-> event_flags_o[irq_src_o];
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt source names a clear flag");

    property p_flag_clear;
        |(~event_flags_o & $past(event_flags_o))
            |-> $past(wr_i) && $past(addr_i) == EVENT_FLAG_REG_IDX;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag dropped without a clearing write");

    // counting only ever steps by one or returns to zero; writes are exempt
    property p_count_step;
        $changed(counter_o) && !$past(wr_i)
            |-> counter_o == 16'($past(counter_o) + 16'h0001) || counter_o == COUNT_ZERO;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter jumped");

    property p_rd_counter;
        rd_i && addr_i == COUNTER_REG_IDX |=> rdata_o == $past(counter_o);
    endproperty
    a_rd_counter: assert property (p_rd_counter)
        else $error("counter read returned wrong value");

    property p_rd_unmapped;
        rd_i && addr_i[3] |=> rdata_o == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");

    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
endmodule // gp_timer_sva

bind gp_timer_up_counting gp_timer_sva #(.PRESC_LOG2(PRESC_LOG2)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i),
    .count_direction_pin_i(count_direction_pin_i), .adc_start_o(adc_start_o),
    .irq_o(irq_o), .irq_src_o(irq_src_o), .event_flags_o(event_flags_o),
    .counter_o(counter_o)
);

//--- verif/gp_timer_up_counting_test.sv
`timescale 1ns/1ns
module gp_timer_up_counting_test
    import gp_timer_pkg::*;
;
    typedef struct {logic [15:0] v; string s;} note_s;
    logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        ext_clk_i = 1'b0, count_direction_pin_i = 1'b0, rd_pend = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, r;
    logic [15:0] rdata_o, counter_o;
    logic        adc_start_o, irq_o;
    logic [1:0]  irq_src_o;
    logic [3:0]  event_flags_o;
    int          miscompares = 0, num_checks = 0, adc_cnt = 0, n;
    integer      seed = 32'hdd548804;
    note_s       exp_q[$];

    gp_timer_up_counting #(.PRESC_LOG2(7)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i),
        .count_direction_pin_i(count_direction_pin_i), .adc_start_o(adc_start_o),
        .irq_o(irq_o), .irq_src_o(irq_src_o), .event_flags_o(event_flags_o),
        .counter_o(counter_o));

    always #50 clk_i = ~clk_i;
    // external source at one eighth of the cpu clock, inside the quarter limit
    always begin
        repeat (4) @(posedge clk_i);
        ext_clk_i <= ~ext_clk_i;
    end

    task check(input string s, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // register port master and read monitor
    // ------------------------------------------------------------
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [15:0] e, input string s);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        exp_q.push_back('{e, s});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    // counts cycles until the counter leaves and then reaches v again
    task wait_cnt(input logic [15:0] v, output int cyc);
        bit left;
        cyc = 0;
        left = 1'b0;
        repeat (200) begin
            @(negedge clk_i);
            cyc++;
            if (counter_o !== v) left = 1'b1;
            else if (left) return;
        end
        miscompares++;
        stop_test();
    endtask

    always @(posedge clk_i) rd_pend <= rd_i;
    // sampled mid-cycle so the read data has settled
    always @(negedge clk_i) begin
        note_s nt;
        if (rd_pend === 1'b1 && exp_q.size() > 0) begin
            nt = exp_q.pop_front();
            check(nt.s, rdata_o, nt.v);
        end
        if (adc_start_o === 1'b1) adc_cnt++;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rd(4'(i), 16'(i == 1) << GRP_DIR_BIT, "reset value");
        r = $random(seed);
        wr(4'h8, r);
        rd(4'h8, 16'h0000, "unmapped");
        wr(PERIOD_REG_IDX, 16'h0003);
        rd(PERIOD_ACTIVE_REG_IDX, 16'h0003, "working period");
        wr(EVENT_MASK_REG_IDX, 16'h000F);
        wr(TIMER_GROUP_CONTROL_REG_IDX, 16'h0080);
        wr(TIMER_CONTROL_REG_IDX, 16'h0840);
        for (int i = 1; i <= 8; i++) begin
            @(negedge clk_i);
            check("counter", counter_o, 16'((i >= 2 && i <= 4) ? i - 1 : 0));
            check("flags", {12'h000, event_flags_o}, 16'((i >= 3 ? 4 : 0) | (i >= 6 ? 1 : 0)));
            check("adc", {15'h0000, adc_start_o}, 16'(i == 3 || i == 7));
            check("irq src", {14'h0000, irq_src_o}, 16'((i >= 3 && i < 6) ? 2 : 0));
        end
        rd(TIMER_CONTROL_REG_IDX, 16'h0800, "enable cleared");
        repeat (20) @(posedge clk_i);
        rd(COUNTER_REG_IDX, 16'h0000, "held at zero");
        rd(EVENT_FLAG_REG_IDX, 16'h0005, "no more flags");
        check("adc pulses", 16'(adc_cnt), 16'h0002);
        wr(EVENT_FLAG_REG_IDX, 16'h000F);
        count_direction_pin_i <= 1'($random(seed));
        wr(COUNTER_REG_IDX, 16'hFFFE);
        wr(TIMER_CONTROL_REG_IDX, 16'h1140);
        wait_cnt(16'h0002, n);
        wait_cnt(16'h0002, n);
        check("period len", 16'(n), 16'h0008);
        rd(EVENT_FLAG_REG_IDX, 16'h000D, "wrap flags");
        rd(TIMER_GROUP_CONTROL_REG_IDX, 16'h2080, "direction");
        wr(TIMER_CONTROL_REG_IDX, 16'h1150);
        wait_cnt(16'h0002, n);
        wait_cnt(16'h0002, n);
        check("ext period len", 16'(n), 16'h0040);
        wr(TIMER_CONTROL_REG_IDX, 16'h0040);
        r = $random(seed);
        wr(COUNTER_REG_IDX, r);
        repeat (20) @(posedge clk_i);
        rd(COUNTER_REG_IDX, r, "stop hold");
        wr(TIMER_CONTROL_REG_IDX, 16'h1100);
        r = $random(seed);
        wr(COUNTER_REG_IDX, r);
        repeat (20) @(posedge clk_i);
        rd(COUNTER_REG_IDX, r, "disabled");
        wr(EVENT_FLAG_REG_IDX, 16'h000F);
        wr(COUNTER_REG_IDX, 16'h0003);
        wr(TIMER_CONTROL_REG_IDX, 16'h0840);
        repeat (12) @(posedge clk_i);
        rd(EVENT_FLAG_REG_IDX, 16'h0005, "start at period");
        rd(TIMER_CONTROL_REG_IDX, 16'h0800, "single ended");
        wr(EVENT_FLAG_REG_IDX, 16'h000F);
        wr(COMPARE_REG_IDX, 16'h0002);
        wr(TIMER_GROUP_CONTROL_REG_IDX, 16'h0180);
        adc_cnt = 0;
        wr(TIMER_CONTROL_REG_IDX, 16'h0842);
        repeat (12) @(posedge clk_i);
        rd(EVENT_FLAG_REG_IDX, 16'h0007, "compare flag");
        check("adc compare", 16'(adc_cnt), 16'h0001);
        wr(EVENT_MASK_REG_IDX, 16'h0000);
        @(negedge clk_i);
        check("masked irq", {15'h0000, irq_o}, 16'h0000);
        wr(EVENT_MASK_REG_IDX, 16'h0006);
        @(negedge clk_i);
        check("irq", {15'h0000, irq_o}, 16'h0001);
        check("irq pick", {14'h0000, irq_src_o}, 16'h0001);
        wr(EVENT_FLAG_REG_IDX, 16'h000F);
        wr(COUNTER_REG_IDX, 16'h0003);
        wr(TIMER_CONTROL_REG_IDX, 16'h1040);
        repeat (12) @(posedge clk_i);
        rd(EVENT_FLAG_REG_IDX, 16'h0005, "cont start at period");
        rd(TIMER_CONTROL_REG_IDX, 16'h1040, "cont keeps running");
        repeat (3) @(posedge clk_i);
        stop_test();
    end
endmodule // gp_timer_up_counting_test
